// ==== hdl/tax_aux_registers.sv ====
// Auxiliary host register set of the converter board
// Operation
// R1: A 16-bit read/write register chooses the source of the programmable output.
// R2: Select codes 0..3 route data ready, buffer full, almost full, error.
// R3: Command words written to the micro register are forwarded to the microcontroller.
// R4: Read-only handshake register carries read permit and write permit flags.
// R5: Host accesses the micro register only while the matching permit is set; the logic here does not check either permit.
// R6: A 32-bit scratch register reads back its last written value.
// R7: A 16-bit scratch register reads back its last written value.
// R8: Flash select bit 0 drives the active-low chip select; reset deselects.
// R9: Each flash operation is framed by clearing and then setting the select bit.
// R10: A write to the flash byte register shifts its low byte out serially.
// R11: A read of the flash byte register shifts in eight bits and returns them.
// R12: Host treats the flash as 2048 pages of 264 bytes, 256 used.
// R13: Low eight bits of the page register pick the lookup page; reset page zero.
// R14: With readback enabled, the page reads as 16-bit words at 0x8000..0x81FE.
// R15: The lookup table spans one 25 ns period: 256 or 128 entries.
// R16: With the queue enabled, each stored event pushes count and length words.
// R17: A 32-bit read of the queue head returns and removes the oldest word.
// R18: A read-only register reports the number of queued words.
// R19: Queue data flag is one while the queue holds any word.
// R20: Queue full flag is one when the queue holds 1024 words.
// R21: With the queue enabled, board full is buffer full or queue full.
`timescale 1ns/1ps
module tax_aux_registers import tax_pkg::*; (
    input  wire logic                        mclk_i,
    input  wire logic                        reset_i,
    // Host access port
    input  wire logic                        host_valid_i,
    input  wire tax_host_req_t               host_req_i,
    output logic                             host_ack_o,
    output logic [31:0]                      host_rdata_o,
    // Board conditions and controls
    input  wire logic                        data_ready_i,
    input  wire logic                        buf_full_i,
    input  wire logic                        almost_full_flag_i,
    input  wire logic                        error_i,
    input  wire logic                        length_queue_en_i,
    input  wire logic                        lut_read_en_i,
    output logic                             prog_out_o,
    output logic                             board_full_o,
    // Event bookkeeping from the output buffer
    input  wire logic                        event_stored_i,
    input  wire logic [15:0]                 event_count_i,
    input  wire logic [15:0]                 event_words_i,
    // Microcontroller side
    input  wire logic                        micro_read_ok_i,
    input  wire logic                        micro_write_ok_i,
    input  wire logic                        micro_reply_valid_i,
    input  wire logic [15:0]                 micro_reply_i,
    output logic [15:0]                      micro_cmd_o,
    output logic                             micro_cmd_valid_o,
    output logic                             micro_reply_taken_o,
    // Serial flash
    output logic                             flash_cs_n_o,
    output logic                             flash_sck_o,
    output logic                             flash_mosi_o,
    input  wire logic                        flash_miso_i,
    // Lookup SRAM, asynchronous read
    output logic [15:0]                      lut_addr_o,
    input  wire logic [15:0]                 lut_data_i
);
    typedef enum logic [1:0] {ST_IDLE, ST_FLASH, ST_LUT} tax_state_t;

    tax_state_t                   state_reg;
    tax_state_t                   state_next;
    tax_host_req_t                req_reg;
    logic [15:0]                  prog_sel_reg;
    logic [15:0]                  micro_cmd_reg;
    logic                         micro_cmd_valid_reg;
    logic [15:0]                  micro_reply_reg;
    logic                         micro_taken_reg;
    logic [31:0]                  scratch_w_reg;
    logic [15:0]                  scratch_n_reg;
    logic [15:0]                  flash_cs_reg;
    logic [15:0]                  lut_page_reg;
    logic [31:0]                  rdata_reg;
    logic [31:0]                  rdata_next;
    logic                         ack_reg;
    logic                         ack_next;
    logic                         prog_out_reg;
    logic                         prog_out_next;

    tax_queue_word_t              queue_head;
    logic [TAX_QUEUE_LVL_W-1:0]   queue_level;
    logic                         queue_full;
    logic                         flash_done;
    logic [7:0]                   flash_rx;

    // Address decode
    wire [15:0] a          = host_req_i.addr;
    wire        take       = state_reg == ST_IDLE && host_valid_i;
    wire        wr         = take && host_req_i.write;
    wire        rd         = take && !host_req_i.write;
    wire        hit_prog   = a == TAX_OFF_PROG_SEL;
    wire        hit_micro  = a == TAX_OFF_MICRO_CMD;
    wire        hit_hs     = a == TAX_OFF_MICRO_HS;
    wire        hit_cs     = a == TAX_OFF_FLASH_CS;
    wire        hit_flash  = a == TAX_OFF_FLASH_BYTE;
    wire        hit_page   = a == TAX_OFF_LUT_PAGE;
    wire        hit_head   = a == TAX_OFF_QUEUE_HEAD;
    wire        hit_level  = a == TAX_OFF_QUEUE_LEVEL;
    wire        hit_flags  = a == TAX_OFF_QUEUE_FLAGS;
    wire        hit_scr_w  = a == TAX_OFF_SCRATCH_W;
    wire        hit_scr_n  = a == TAX_OFF_SCRATCH_N;
    wire        hit_lut    = a >= TAX_OFF_LUT_FIRST && a <= TAX_OFF_LUT_LAST;
    wire        flash_go   = take && hit_flash;
    wire        lut_go     = rd && hit_lut && lut_read_en_i; // R14
    wire        queue_pop  = rd && hit_head && host_req_i.wide; // R17
    wire        queue_push = event_stored_i && length_queue_en_i; // R16
    wire        queue_has  = queue_level != '0; // R19

    wire [15:0] hs_word    = 16'((micro_read_ok_i << TAX_HS_READ_OK_BIT)
                                 | (micro_write_ok_i << TAX_HS_WRITE_OK_BIT)); // R4
    wire [15:0] flags_word = 16'((queue_has << TAX_QF_HAS_DATA_BIT)
                                 | (queue_full << TAX_QF_FULL_BIT)); // R19 R20
    wire [15:0] lut_index  = 16'(req_reg.addr[TAX_LUT_IDX_W:1]);

    // Lookup page readback
    assign lut_addr_o = {lut_page_reg[TAX_PAGE_W-1:0], lut_index[TAX_LUT_IDX_W-1:0]}; // R13 R15

    tax_flash_shift u_flash (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .start_i (flash_go),
        .write_i (host_req_i.write),
        .byte_i  (host_req_i.wdata[7:0]),
        .miso_i  (flash_miso_i),
        .sck_o   (flash_sck_o),
        .mosi_o  (flash_mosi_o),
        .done_o  (flash_done),
        .byte_o  (flash_rx)
    );

    tax_length_queue u_queue (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .push_i  (queue_push),
        .word_i  ('{event_count: event_count_i, word_count: event_words_i}),
        .pop_i   (queue_pop),
        .head_o  (queue_head),
        .level_o (queue_level),
        .full_o  (queue_full)
    );

    // Access sequencing
    always_comb begin
        state_next = state_reg;
        ack_next   = 1'b0;
        rdata_next = rdata_reg;
        case (state_reg)
            ST_IDLE: begin
                if (flash_go) begin
                    state_next = ST_FLASH;
                end else if (lut_go) begin
                    state_next = ST_LUT;
                end else if (take) begin
                    ack_next   = 1'b1;
                    rdata_next = 32'h0000_0000;
                    if (rd) begin
                        if (hit_prog)  rdata_next = {16'h0000, prog_sel_reg}; // R1
                        if (hit_micro) rdata_next = {16'h0000, micro_reply_reg};
                        if (hit_hs)    rdata_next = {16'h0000, hs_word}; // R4
                        if (hit_cs)    rdata_next = {16'h0000, flash_cs_reg};
                        if (hit_page)  rdata_next = {16'h0000, lut_page_reg};
                        if (hit_head)  rdata_next = host_req_i.wide ? queue_head
                                                    : {16'h0000, queue_head.word_count};
                        if (hit_level) rdata_next = 32'(queue_level); // R18
                        if (hit_flags) rdata_next = {16'h0000, flags_word};
                        if (hit_scr_w) rdata_next = host_req_i.wide ? scratch_w_reg
                                                    : {16'h0000, scratch_w_reg[15:0]}; // R6
                        if (hit_scr_n) rdata_next = {16'h0000, scratch_n_reg}; // R7
                    end
                end
            end
            ST_FLASH: begin
                if (flash_done) begin
                    state_next = ST_IDLE;
                    ack_next   = 1'b1;
                    rdata_next = req_reg.write ? 32'h0000_0000 : {24'h000000, flash_rx}; // R11
                end
            end
            ST_LUT: begin
                state_next = ST_IDLE;
                ack_next   = 1'b1;
                rdata_next = {16'h0000, lut_data_i}; // R14
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Programmable output source
    always_comb begin
        case (tax_prog_sel_t'(prog_sel_reg[2:0]))
            TAX_SEL_DATA_READY:  prog_out_next = data_ready_i; // R2
            TAX_SEL_BUF_FULL:    prog_out_next = buf_full_i;
            TAX_SEL_ALMOST_FULL: prog_out_next = almost_full_flag_i;
            TAX_SEL_ERROR:       prog_out_next = error_i;
            default:             prog_out_next = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            req_reg   <= '0;
            rdata_reg <= 32'h0000_0000;
            ack_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
            if (take) begin
                req_reg <= host_req_i;
            end
        end
    end

    // Host-written registers
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            prog_sel_reg  <= TAX_PROG_SEL_RST;
            micro_cmd_reg <= 16'h0000;
            scratch_w_reg <= 32'h0000_0000;
            scratch_n_reg <= 16'h0000;
            flash_cs_reg  <= TAX_FLASH_CS_RST;
            lut_page_reg  <= TAX_LUT_PAGE_RST;
        end else if (wr) begin
            if (hit_prog)  prog_sel_reg  <= host_req_i.wdata[15:0]; // R1
            if (hit_micro) micro_cmd_reg <= host_req_i.wdata[15:0]; // R3
            if (hit_scr_w) scratch_w_reg <= host_req_i.wide ? host_req_i.wdata
                                            : {scratch_w_reg[31:16], host_req_i.wdata[15:0]}; // R6
            if (hit_scr_n) scratch_n_reg <= host_req_i.wdata[15:0]; // R7
            if (hit_cs)    flash_cs_reg  <= host_req_i.wdata[15:0]; // R8 R9
            if (hit_page)  lut_page_reg  <= host_req_i.wdata[15:0]; // R13
        end
    end

    // Micro exchange and programmable output register
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            micro_cmd_valid_reg <= 1'b0;
            micro_taken_reg     <= 1'b0;
            micro_reply_reg     <= 16'h0000;
            prog_out_reg        <= 1'b0;
        end else begin
            micro_cmd_valid_reg <= wr && hit_micro; // R3
            micro_taken_reg     <= rd && hit_micro;
            prog_out_reg        <= prog_out_next;
            if (micro_reply_valid_i) begin
                micro_reply_reg <= micro_reply_i;
            end
        end
    end

    assign host_ack_o          = ack_reg;
    assign host_rdata_o        = rdata_reg;
    assign micro_cmd_o         = micro_cmd_reg;
    assign micro_cmd_valid_o   = micro_cmd_valid_reg;
    assign micro_reply_taken_o = micro_taken_reg;
    assign flash_cs_n_o        = flash_cs_reg[TAX_FLASH_CS_BIT]; // R8
    assign prog_out_o          = prog_out_reg;
    assign board_full_o        = buf_full_i || (length_queue_en_i && queue_full); // R21
endmodule : tax_aux_registers

// ==== hdl/tax_pkg.sv ====
// Shared constants and types for the auxiliary register set
package tax_pkg;
    // Register offsets
    localparam logic [15:0] TAX_OFF_PROG_SEL    = 16'h102c;
    localparam logic [15:0] TAX_OFF_MICRO_CMD   = 16'h102e;
    localparam logic [15:0] TAX_OFF_MICRO_HS    = 16'h1030;
    localparam logic [15:0] TAX_OFF_FLASH_CS    = 16'h1032;
    localparam logic [15:0] TAX_OFF_FLASH_BYTE  = 16'h1034;
    localparam logic [15:0] TAX_OFF_LUT_PAGE    = 16'h1036;
    localparam logic [15:0] TAX_OFF_QUEUE_HEAD  = 16'h1038;
    localparam logic [15:0] TAX_OFF_QUEUE_LEVEL = 16'h103c;
    localparam logic [15:0] TAX_OFF_QUEUE_FLAGS = 16'h103e;
    localparam logic [15:0] TAX_OFF_SCRATCH_W   = 16'h1200;
    localparam logic [15:0] TAX_OFF_SCRATCH_N   = 16'h1204;
    localparam logic [15:0] TAX_OFF_LUT_FIRST   = 16'h8000;
    localparam logic [15:0] TAX_OFF_LUT_LAST    = 16'h81fe;

    // Reset values
    localparam logic [15:0] TAX_PROG_SEL_RST = 16'h0000;
    localparam logic [15:0] TAX_FLASH_CS_RST = 16'h0001;
    localparam logic [15:0] TAX_LUT_PAGE_RST = 16'h0000;

    // Field positions
    localparam int TAX_HS_READ_OK_BIT  = 0;
    localparam int TAX_HS_WRITE_OK_BIT = 1;
    localparam int TAX_QF_HAS_DATA_BIT = 0;
    localparam int TAX_QF_FULL_BIT     = 1;
    localparam int TAX_FLASH_CS_BIT    = 0;
    localparam int TAX_PAGE_W          = 8;

    // Lookup table geometry: one converter period
    localparam int TAX_LUT_WORDS_FINE   = 256;
    localparam int TAX_LUT_WORDS_COARSE = 128;
    localparam int TAX_LUT_IDX_W       = $clog2(TAX_LUT_WORDS_FINE);

    // Length queue
    localparam int TAX_QUEUE_DEPTH = 1024;
    localparam int TAX_QUEUE_PTR_W = 10;
    localparam int TAX_QUEUE_LVL_W = 11;

    // Serial flash clock timing
    localparam int TAX_CLK_PERIOD_NS   = 20;
    localparam int TAX_SCK_HALF_NS     = 40;
    localparam int TAX_SCK_HALF_CYCLES = (TAX_SCK_HALF_NS + TAX_CLK_PERIOD_NS - 1) / TAX_CLK_PERIOD_NS;
    localparam int TAX_FLASH_BITS      = 8;

    typedef enum logic [2:0] {
        TAX_SEL_DATA_READY  = 3'h0,
        TAX_SEL_BUF_FULL    = 3'h1,
        TAX_SEL_ALMOST_FULL = 3'h2,
        TAX_SEL_ERROR       = 3'h3
    } tax_prog_sel_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        write;
        logic        wide;
    } tax_host_req_t;

    typedef struct packed {
        logic [15:0] event_count;
        logic [15:0] word_count;
    } tax_queue_word_t;
endpackage : tax_pkg

// ==== hdl/tax_flash_shift.sv ====
// Byte-wide serial shifter toward the flash
`timescale 1ns/1ps
module tax_flash_shift import tax_pkg::*; (
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic       start_i,
    input  wire logic       write_i,
    input  wire logic [7:0] byte_i,
    input  wire logic       miso_i,
    output logic            sck_o,
    output logic            mosi_o,
    output logic            done_o,
    output logic [7:0]      byte_o
);
    logic       busy_reg;
    logic       sck_reg;
    logic       done_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic [2:0] bits_reg;
    logic [1:0] div_reg;
    wire        tick = busy_reg && (div_reg == 2'(TAX_SCK_HALF_CYCLES - 1));

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            busy_reg <= 1'b0;
            sck_reg  <= 1'b0;
            done_reg <= 1'b0;
            tx_reg   <= 8'h00;
            rx_reg   <= 8'h00;
            bits_reg <= 3'h0;
            div_reg  <= 2'h0;
        end else begin
            done_reg <= 1'b0;
            div_reg  <= tick || !busy_reg ? 2'h0 : div_reg + 2'h1;
            if (start_i && !busy_reg) begin
                busy_reg <= 1'b1;
                tx_reg   <= write_i ? byte_i : 8'h00; // R10 R11
                bits_reg <= 3'h0;
            end else if (tick && !sck_reg) begin
                sck_reg <= 1'b1;
                rx_reg  <= {rx_reg[6:0], miso_i}; // R11
            end else if (tick) begin
                sck_reg  <= 1'b0;
                tx_reg   <= {tx_reg[6:0], 1'b0}; // R10
                bits_reg <= bits_reg + 3'h1;
                if (bits_reg == 3'(TAX_FLASH_BITS - 1)) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
            end
        end
    end

    assign sck_o  = sck_reg;
    assign mosi_o = tx_reg[7];
    assign done_o = done_reg;
    assign byte_o = rx_reg;
endmodule : tax_flash_shift

// ==== hdl/tax_length_queue.sv ====
// Event length queue held in flip-flops
`timescale 1ns/1ps
module tax_length_queue import tax_pkg::*; (
    input  wire logic                       mclk_i,
    input  wire logic                       reset_i,
    input  wire logic                       push_i,
    input  wire tax_queue_word_t            word_i,
    input  wire logic                       pop_i,
    output tax_queue_word_t                 head_o,
    output logic [TAX_QUEUE_LVL_W-1:0]      level_o,
    output logic                            full_o
);
    tax_queue_word_t               mem_reg [TAX_QUEUE_DEPTH];
    logic [TAX_QUEUE_PTR_W-1:0]    wr_ptr_reg;
    logic [TAX_QUEUE_PTR_W-1:0]    rd_ptr_reg;
    logic [TAX_QUEUE_LVL_W-1:0]    level_reg;
    wire                           full  = level_reg == TAX_QUEUE_LVL_W'(TAX_QUEUE_DEPTH);
    wire                           empty = level_reg == '0;
    wire                           do_push = push_i && !full;
    wire                           do_pop  = pop_i && !empty;

    for (genvar i = 0; i < TAX_QUEUE_DEPTH; i++) begin : g_entry
        always_ff @(posedge mclk_i) begin
            if (do_push && wr_ptr_reg == TAX_QUEUE_PTR_W'(i)) begin
                mem_reg[i] <= word_i; // R16
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + TAX_QUEUE_PTR_W'(do_push);
            rd_ptr_reg <= rd_ptr_reg + TAX_QUEUE_PTR_W'(do_pop); // R17
            level_reg  <= level_reg + TAX_QUEUE_LVL_W'(do_push) - TAX_QUEUE_LVL_W'(do_pop); // R18
        end
    end

    assign head_o  = empty ? '0 : mem_reg[rd_ptr_reg];
    assign level_o = level_reg;
    assign full_o  = full; // R20
endmodule : tax_length_queue

// ==== test/tax_flash_model.sv ====
// Behavioural serial flash answering byte shifts
`timescale 1ns/1ps
module tax_flash_model (
    input  wire logic       cs_n_i,
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    output logic [7:0]      rx_o
);
    localparam logic [7:0] REPLY = 8'h5a;
    logic [2:0] idx = 3'h7;
    initial rx_o = 8'h00;
    // Select fall restarts a byte
    always @(negedge cs_n_i) idx = 3'h7;
    always @(posedge sck_i) rx_o = {rx_o[6:0], mosi_i};
    always @(negedge sck_i) idx = idx - 3'h1;
    // Deselected: inverted data
    assign miso_o = cs_n_i ? ~REPLY[idx] : REPLY[idx];
endmodule : tax_flash_model

// ==== test/tax_aux_registers_sva.sv ====
// Port checker for the auxiliary register set
`timescale 1ns/1ps
module tax_aux_sva import tax_pkg::*; (
    input wire logic            mclk_i,
    input wire logic            reset_i,
    input wire logic            host_valid_i,
    input wire tax_host_req_t   host_req_i,
    input wire logic            host_ack_o,
    input wire logic [31:0]     host_rdata_o,
    input wire logic            buf_full_i,
    input wire logic            length_queue_en_i,
    input wire logic            lut_read_en_i,
    input wire logic            board_full_o,
    input wire logic            micro_read_ok_i,
    input wire logic            micro_write_ok_i,
    input wire logic [15:0]     micro_cmd_o,
    input wire logic            micro_cmd_valid_o,
    input wire logic            flash_cs_n_o,
    input wire logic            flash_sck_o,
    input wire logic            flash_mosi_o,
    input wire logic [15:0]     lut_addr_o,
    input wire logic [15:0]     lut_data_i
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    wire wr_go = host_valid_i && host_req_i.write;
    wire rd_go = host_valid_i && !host_req_i.write;
    wire lut_go = rd_go && lut_read_en_i && host_req_i.addr >= TAX_OFF_LUT_FIRST && host_req_i.addr <= TAX_OFF_LUT_LAST;
    a_reset_idle: assert property ($fell(reset_i) |-> flash_cs_n_o && !flash_sck_o && !host_ack_o)
        else $error("reset state");
    a_cs_from_write: assert property (wr_go && host_req_i.addr == TAX_OFF_FLASH_CS
        |=> flash_cs_n_o == $past(host_req_i.wdata[0])) else $error("cs bit");
    a_cmd_forward: assert property (wr_go && host_req_i.addr == TAX_OFF_MICRO_CMD
        |=> micro_cmd_valid_o && micro_cmd_o == $past(host_req_i.wdata[15:0])) else $error("cmd");
    a_hs_flags: assert property (rd_go && host_req_i.addr == TAX_OFF_MICRO_HS |=> host_ack_o
        && host_rdata_o == {30'h0, $past(micro_write_ok_i), $past(micro_read_ok_i)}) else $error("hs");
    a_full_merge: assert property ((buf_full_i || !length_queue_en_i) |-> board_full_o == buf_full_i)
        else $error("full");
    a_mosi_msb: assert property (wr_go && host_req_i.addr == TAX_OFF_FLASH_BYTE
        |=> flash_mosi_o == $past(host_req_i.wdata[7])) else $error("msb");
    a_flash_span: assert property (host_valid_i && host_req_i.addr == TAX_OFF_FLASH_BYTE
        |=> (!host_ack_o)[*8] ##[20:32] host_ack_o) else $error("flash span");
    a_lut_addr: assert property (lut_go |=> lut_addr_o[7:0] == $past(host_req_i.addr[8:1]))
        else $error("lut addr");
    a_lut_data: assert property (lut_go |=> !host_ack_o ##1 host_ack_o
        && host_rdata_o == {16'h0, $past(lut_data_i)}) else $error("lut data");
    c_flash: cover property (host_valid_i && host_req_i.addr == TAX_OFF_FLASH_BYTE);
    c_lut: cover property (lut_go);
    c_full: cover property (board_full_o && !buf_full_i);
endmodule : tax_aux_sva
bind tax_aux_registers tax_aux_sva u_sva (.mclk_i, .reset_i, .host_valid_i, .host_req_i, .host_ack_o,
    .host_rdata_o, .buf_full_i, .length_queue_en_i, .lut_read_en_i, .board_full_o, .micro_read_ok_i,
    .micro_write_ok_i, .micro_cmd_o, .micro_cmd_valid_o, .flash_cs_n_o, .flash_sck_o, .flash_mosi_o,
    .lut_addr_o, .lut_data_i);

// ==== test/tb_tax_aux_registers.sv ====
// Testbench for the auxiliary register set
`timescale 1ns/1ps
module tb_tax_aux_registers import tax_pkg::*;;
    logic mclk_i = 0, reset_i = 1, host_valid_i = 0, host_ack_o, prog_out_o, board_full_o;
    tax_host_req_t host_req_i = '0;
    logic data_ready_i = 0, buf_full_i = 0, almost_full_flag_i = 0, error_i = 0;
    logic length_queue_en_i = 0, lut_read_en_i = 0, event_stored_i = 0;
    logic micro_read_ok_i = 0, micro_write_ok_i = 0, micro_reply_valid_i = 0, micro_cmd_valid_o;
    logic micro_reply_taken_o, flash_cs_n_o, flash_sck_o, flash_mosi_o, flash_miso_i;
    logic [15:0] event_count_i = 0, event_words_i = 0, micro_reply_i = 0, micro_cmd_o, lut_addr_o, lut_data_i;
    logic [31:0] host_rdata_o;
    logic [7:0]  flash_rx;
    int num_errors = 0, num_checks = 0, cyc = 0;
    tax_aux_registers DUT (.mclk_i, .reset_i, .host_valid_i, .host_req_i, .host_ack_o, .host_rdata_o,
        .data_ready_i, .buf_full_i, .almost_full_flag_i, .error_i, .length_queue_en_i, .lut_read_en_i,
        .prog_out_o, .board_full_o, .event_stored_i, .event_count_i, .event_words_i, .micro_read_ok_i,
        .micro_write_ok_i, .micro_reply_valid_i, .micro_reply_i, .micro_cmd_o, .micro_cmd_valid_o,
        .micro_reply_taken_o, .flash_cs_n_o, .flash_sck_o, .flash_mosi_o, .flash_miso_i, .lut_addr_o,
        .lut_data_i);
    tax_flash_model u_flash (.cs_n_i(flash_cs_n_o), .sck_i(flash_sck_o), .mosi_i(flash_mosi_o),
        .miso_o(flash_miso_i), .rx_o(flash_rx));
    assign lut_data_i = {lut_addr_o[15:8], ~lut_addr_o[7:0]};
    always #10 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic acc(input logic w, input logic wd, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(negedge mclk_i);
        host_valid_i = 1;
        host_req_i = '{a, d, w, wd};
        @(negedge mclk_i);
        host_valid_i = 0;
        while (host_ack_o !== 1'b1 && n < 100) begin
            @(negedge mclk_i);
            n++;
        end
        if (n == 100) chk("ack", 1, 0);
        q = host_rdata_o;
    endtask : acc
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic wd = 0);
        logic [31:0] q;
        acc(1, wd, a, d, q);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic wd, input logic [31:0] exp);
        logic [31:0] q;
        acc(0, wd, a, 0, q);
        chk($sformatf("read %h", a), exp, q);
    endtask : rd
    initial begin
        repeat (6) @(negedge mclk_i);
        reset_i = 0;
        chk("cs_n", 1, flash_cs_n_o);
        rd(TAX_OFF_FLASH_CS, 0, 1);
        rd(TAX_OFF_PROG_SEL, 0, 0);
        rd(16'h1100, 0, 0);
        for (int s = 0; s < 5; s++) begin
            wr(TAX_OFF_PROG_SEL, s);
            rd(TAX_OFF_PROG_SEL, 0, s);
            {error_i, almost_full_flag_i, buf_full_i, data_ready_i} = (s < 4) ? 4'h1 << s : 4'hf;
            repeat (2) @(negedge mclk_i);
            chk("prog_on", s < 4, prog_out_o);
            {error_i, almost_full_flag_i, buf_full_i, data_ready_i} = (s < 4) ? ~(4'h1 << s) : 4'h0;
            repeat (2) @(negedge mclk_i);
            chk("prog_off", 0, prog_out_o);
        end
        buf_full_i = 0;
        micro_read_ok_i = 1;
        rd(TAX_OFF_MICRO_HS, 0, 1);
        micro_read_ok_i = 0;
        micro_write_ok_i = 1;
        rd(TAX_OFF_MICRO_HS, 0, 2);
        wr(TAX_OFF_MICRO_CMD, 16'h3a5c);
        chk("cmd", 16'h3a5c, micro_cmd_o);
        micro_reply_i = 16'h7e81;
        micro_reply_valid_i = 1;
        @(negedge mclk_i);
        micro_reply_valid_i = 0;
        micro_read_ok_i = 1;
        rd(TAX_OFF_MICRO_CMD, 0, 16'h7e81);
        chk("taken", 1, micro_reply_taken_o);
        wr(TAX_OFF_SCRATCH_W, 32'h1234abcd, 1);
        rd(TAX_OFF_SCRATCH_W, 1, 32'h1234abcd);
        wr(TAX_OFF_SCRATCH_W, 16'h5555);
        rd(TAX_OFF_SCRATCH_W, 1, 32'h12345555);
        wr(TAX_OFF_SCRATCH_N, 16'hbeef);
        rd(TAX_OFF_SCRATCH_N, 0, 16'hbeef);
        wr(TAX_OFF_FLASH_CS, 0);
        chk("cs_n", 0, flash_cs_n_o);
        wr(TAX_OFF_FLASH_BYTE, 16'h01c3);
        chk("flash_rx", 8'hc3, flash_rx);
        rd(TAX_OFF_FLASH_BYTE, 0, 8'h5a);
        wr(TAX_OFF_FLASH_CS, 1);
        chk("cs_n", 1, flash_cs_n_o);
        lut_read_en_i = 1;
        rd(16'h8002, 0, 16'h00fe);
        wr(TAX_OFF_LUT_PAGE, 16'h01a7);
        rd(16'h8006, 0, 16'ha7fc);
        rd(TAX_OFF_LUT_LAST, 0, 16'ha700);
        lut_read_en_i = 0;
        rd(TAX_OFF_LUT_FIRST, 0, 0);
        length_queue_en_i = 1;
        rd(TAX_OFF_QUEUE_FLAGS, 0, 0);
        for (int i = 0; i < 1025; i++) begin
            @(negedge mclk_i);
            event_stored_i = 1;
            event_count_i = i[15:0];
            event_words_i = i[15:0] + 16'h10;
        end
        @(negedge mclk_i);
        event_stored_i = 0;
        rd(TAX_OFF_QUEUE_LEVEL, 0, 1024);
        rd(TAX_OFF_QUEUE_FLAGS, 0, 3);
        chk("board_full", 1, board_full_o);
        rd(TAX_OFF_QUEUE_HEAD, 0, 16'h10);
        rd(TAX_OFF_QUEUE_HEAD, 1, 32'h00000010);
        rd(TAX_OFF_QUEUE_FLAGS, 0, 1);
        for (int i = 1; i < 1024; i++) rd(TAX_OFF_QUEUE_HEAD, 1, {i[15:0], i[15:0] + 16'h10});
        rd(TAX_OFF_QUEUE_LEVEL, 0, 0);
        rd(TAX_OFF_QUEUE_FLAGS, 0, 0);
        test_done();
    end
endmodule : tb_tax_aux_registers
